// ===== rtl/synth_serial_load_and_power_ctrl.sv
// Overview of operation
// - every rising serial clock edge shifts one data bit into a 32-bit register.
// - words arrive msb first; the four lowest bits name the target register.
// - a rising load strobe copies the shifted word into the named register.
// - chip enable low powers down and puts the charge pump output in high impedance.
// - chip enable high powers up only as far as the software power-down bit allows.
// - loaded register contents survive a chip-enable power-down.
// - rf power-down pin low disables only the main rf output; a software bit does too.
// - main rf output is off when register 6 enable is clear or the pin is low.
// - monitor output shows lock detects or scaled divider signals as configured.
// - a three-bit field in register 4 selects the monitor source.
//
// The register addresses and the strobed register port were left to the implementer.
`default_nettype none
module synth_serial_load_and_power_ctrl
    import synth_pkg::*;
(
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic sclk,
    input wire logic sdata,
    input wire logic load_strobe,
    input wire logic chip_enable,
    input wire logic rf_output_power_down_n,
    input wire logic charge_pump_drive,
    input wire logic digital_lock_detect,
    input wire logic analog_lock_detect,
    input wire logic scaled_rf_div,
    input wire logic scaled_ref_div,
    input wire logic [BUS_ADDR_W-1:0] bus_addr,
    input wire logic [31:0] bus_wdata,
    input wire logic bus_wr,
    input wire logic bus_rd,
    output logic [31:0] bus_rdata,
    output logic charge_pump_output,
    output logic charge_pump_output_oe,
    output logic chip_powered,
    output logic main_rf_output,
    output logic monitor_mux_output
);
    // ------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------
    logic rst_meta;
    logic rst_n;

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    // ------------------------------------------------------------
    // serial port
    // ------------------------------------------------------------
    load_if lnk();

    serial_shifter u_shifter (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .sclk(sclk),
        .sdata(sdata),
        .load_strobe(load_strobe),
        .chip_enable(chip_enable),
        .rf_output_power_down_n(rf_output_power_down_n),
        .lnk(lnk)
    );

    // ------------------------------------------------------------
    // internal registers
    // ------------------------------------------------------------
    word_t regs [REG_COUNT];
    logic [31:0] control;
    logic [15:0] load_count;
    logic [SEL_W-1:0] last_sel;
    logic accept;
    logic [SEL_W-1:0] load_sel;

    assign accept = lnk.load & control[CTRL_ACCEPT_BIT];
    assign load_sel = lnk.word[SEL_W-1:0];

    // chip enable is deliberately absent here so contents ride through power-down
    // load named register
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < REG_COUNT; i++) begin
                regs[i] <= WORD_RESET;
            end
        end else if (accept) begin
            regs[load_sel] <= lnk.word;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            load_count <= '0;
            last_sel <= '0;
        end else if (accept) begin
            load_count <= load_count + 16'h0001;
            last_sel <= load_sel;
        end
    end

    // ------------------------------------------------------------
    // power and rf output control
    // ------------------------------------------------------------
    logic sw_power_down;
    logic rf_enable_bit;
    mon_sel_e mon_sel;
    logic next_monitor;

    assign sw_power_down = regs[PD_REG][PD_BIT];
    assign rf_enable_bit = regs[RF_EN_REG][RF_EN_BIT];
    assign mon_sel = mon_sel_e'(regs[MUX_REG][MUX_LSB +: MUX_W]);

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            chip_powered <= 1'b0;
            charge_pump_output_oe <= 1'b0;
            charge_pump_output <= 1'b0;
        end else begin
            chip_powered <= lnk.ce_level & ~sw_power_down;
            charge_pump_output_oe <= lnk.ce_level & ~sw_power_down;
            charge_pump_output <= charge_pump_drive;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            main_rf_output <= 1'b0;
        end else begin
            main_rf_output <= lnk.ce_level & ~sw_power_down & rf_enable_bit & lnk.rfpd_n_level;
        end
    end

    always_comb begin
        unique case (mon_sel)
            MON_LOW: next_monitor = 1'b0;
            MON_HIGH: next_monitor = 1'b1;
            MON_REF_DIV: next_monitor = scaled_ref_div;
            MON_RF_DIV: next_monitor = scaled_rf_div;
            MON_ANALOG_LD: next_monitor = analog_lock_detect;
            MON_DIGITAL_LD: next_monitor = digital_lock_detect;
            default: next_monitor = 1'b0;
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            monitor_mux_output <= 1'b0;
        end else begin
            monitor_mux_output <= next_monitor;
        end
    end

    // ------------------------------------------------------------
    // register bus
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            control <= CONTROL_RESET;
        end else if (bus_wr && bus_addr == OFS_CONTROL) begin
            control <= {31'h0000_0000, bus_wdata[CTRL_ACCEPT_BIT]};
        end
    end

    // read data stand only in the cycle after the strobe
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            bus_rdata <= 32'h0000_0000;
        end else if (!bus_rd) begin
            bus_rdata <= 32'h0000_0000;
        end else if (bus_addr < OFS_STATUS && bus_addr[1:0] == 2'b00) begin
            bus_rdata <= regs[bus_addr[5:2]];
        end else if (bus_addr == OFS_STATUS) begin
            bus_rdata <= {load_count, 8'h00, last_sel, 1'b0, main_rf_output, charge_pump_output_oe, chip_powered};
        end else if (bus_addr == OFS_CONTROL) begin
            bus_rdata <= control;
        end else begin
            bus_rdata <= 32'h0000_0000;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    // word lands in named slot
    a_load_target: assert property (@(posedge core_clk) disable iff (!rst_n)
        accept |=> regs[$past(load_sel)] == $past(lnk.word))
        else $error("loaded word not found in its register");

    a_ce_retain: assert property (@(posedge core_clk) disable iff (!rst_n)
        (!lnk.ce_level && !accept) |=> $stable(regs[RF_EN_REG]) && $stable(regs[PD_REG]))
        else $error("register contents changed during power-down");

    a_cp_hiz: assert property (@(posedge core_clk) disable iff (!rst_n)
        !lnk.ce_level |=> !charge_pump_output_oe && !chip_powered)
        else $error("charge pump driven while chip enable low");

    a_power_up: assert property (@(posedge core_clk) disable iff (!rst_n)
        lnk.ce_level |=> chip_powered == !$past(sw_power_down))
        else $error("power state does not follow the software bit");

    a_rf_pin_only: assert property (@(posedge core_clk) disable iff (!rst_n)
        (!lnk.rfpd_n_level && lnk.ce_level && !sw_power_down) |=> chip_powered && !main_rf_output)
        else $error("rf power-down pin reached beyond the rf output");

    // enable bit and pin both needed
    a_rf_enable: assert property (@(posedge core_clk) disable iff (!rst_n)
        ##1 main_rf_output |-> $past(rf_enable_bit) && $past(lnk.rfpd_n_level))
        else $error("rf output on while disabled");

    a_mon_lock: assert property (@(posedge core_clk) disable iff (!rst_n)
        mon_sel == MON_DIGITAL_LD |=> monitor_mux_output == $past(digital_lock_detect))
        else $error("monitor output does not show digital lock detect");

    a_mon_select: assert property (@(posedge core_clk) disable iff (!rst_n)
        mon_sel == MON_REF_DIV |=> monitor_mux_output == $past(scaled_ref_div))
        else $error("monitor select field ignored");
endmodule : synth_serial_load_and_power_ctrl
`default_nettype wire

// ===== inc/synth_pkg.sv
`default_nettype none
package synth_pkg;
    localparam int WORD_W = 32;
    localparam int REG_COUNT = 16;
    localparam int SEL_W = 4;
    // ------------------------------------------------------------
    // pin slots in the synchroniser vector
    // ------------------------------------------------------------
    localparam int PIN_COUNT = 5;
    localparam int PIN_SCLK = 0;
    localparam int PIN_DATA = 1;
    localparam int PIN_LOAD = 2;
    localparam int PIN_CE = 3;
    localparam int PIN_RFPD = 4;
    // ------------------------------------------------------------
    // fields inside the loaded words
    // ------------------------------------------------------------
    localparam int RF_EN_REG = 6;
    localparam int RF_EN_BIT = 6;
    localparam int PD_REG = 4;
    localparam int PD_BIT = 5;
    localparam int MUX_REG = 4;
    localparam int MUX_LSB = 27;
    localparam int MUX_W = 3;
    // ------------------------------------------------------------
    // register bus map (byte addresses)
    // ------------------------------------------------------------
    localparam int BUS_ADDR_W = 8;
    localparam logic [7:0] OFS_WORDS = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h40;
    localparam logic [7:0] OFS_CONTROL = 8'h44;
    localparam int CTRL_ACCEPT_BIT = 0;
    localparam logic [31:0] CONTROL_RESET = 32'h0000_0001;
    localparam logic [31:0] WORD_RESET = 32'h0000_0000;
    typedef logic [WORD_W-1:0] word_t;
    typedef enum logic [MUX_W-1:0] {
        MON_LOW = 3'b000,
        MON_HIGH = 3'b001,
        MON_REF_DIV = 3'b010,
        MON_RF_DIV = 3'b011,
        MON_ANALOG_LD = 3'b100,
        MON_DIGITAL_LD = 3'b101
    } mon_sel_e;
endpackage : synth_pkg
`default_nettype wire

// ===== inc/load_if.sv
`default_nettype none
interface load_if;
    import synth_pkg::*;
    word_t word;
    logic load;
    logic ce_level;
    logic rfpd_n_level;
    modport src(output word, output load, output ce_level, output rfpd_n_level);
    modport dst(input word, input load, input ce_level, input rfpd_n_level);
endinterface : load_if
`default_nettype wire

// ===== rtl/serial_shifter.sv
`default_nettype none
module serial_shifter
    import synth_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic sclk,
    input wire logic sdata,
    input wire logic load_strobe,
    input wire logic chip_enable,
    input wire logic rf_output_power_down_n,
    load_if.src lnk
);
    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [PIN_COUNT-1:0] pins_raw;
    logic [PIN_COUNT-1:0] sync1;
    logic [PIN_COUNT-1:0] sync2;
    logic [PIN_COUNT-1:0] sync3;
    logic [PIN_COUNT-1:0] level;
    logic [PIN_COUNT-1:0] next_level;
    word_t shreg;
    word_t next_shreg;
    logic sclk_rise;
    logic load_rise;

    assign pins_raw = {rf_output_power_down_n, chip_enable, load_strobe, sdata, sclk};
    // a level only moves once the last two stages agree
    assign next_level = (sync2 & sync3) | (level & (sync2 ^ sync3));
    assign sclk_rise = next_level[PIN_SCLK] & ~level[PIN_SCLK];
    assign load_rise = next_level[PIN_LOAD] & ~level[PIN_LOAD];

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            sync1 <= '0;
            sync2 <= '0;
            sync3 <= '0;
            level <= '0;
        end else begin
            sync1 <= pins_raw;
            sync2 <= sync1;
            sync3 <= sync2;
            level <= next_level;
        end
    end

    // ------------------------------------------------------------
    // shift and load
    // ------------------------------------------------------------
    // shift on clock rise
    assign next_shreg = sclk_rise ? {shreg[WORD_W-2:0], next_level[PIN_DATA]} : shreg;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            shreg <= '0;
        end else begin
            shreg <= next_shreg;
        end
    end

    // a clock edge and the strobe may land in one cycle; the shifted word wins
    // strobe rise loads
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            lnk.load <= 1'b0;
            lnk.word <= '0;
        end else begin
            lnk.load <= load_rise;
            lnk.word <= next_shreg;
        end
    end

    assign lnk.ce_level = level[PIN_CE];
    assign lnk.rfpd_n_level = level[PIN_RFPD];

    a_shift_in: assert property (@(posedge core_clk) disable iff (!rst_n)
        sclk_rise |=> shreg == {$past(shreg[WORD_W-2:0]), $past(next_level[PIN_DATA])})
        else $error("shift register did not take the data bit");

    a_shift_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
        !sclk_rise |=> $stable(shreg))
        else $error("shift register moved without a clock edge");
endmodule : serial_shifter
`default_nettype wire

// ===== bench/serial_host.sv
`default_nettype none
module serial_host
    import synth_pkg::*;
(
    input wire logic core_clk,
    output logic sclk,
    output logic sdata,
    output logic load_strobe
);
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------
    // host side of the three-wire load port
    // ------------------------------------------------------------
    initial begin
        sclk = 1'b0;
        sdata = 1'b0;
        load_strobe = 1'b0;
    end
    // link clock rests low between frames; 8 core cycles per bit
    task automatic send_word(input word_t w);
        for (int i = WORD_W - 1; i >= 0; i--) begin
            sdata <= w[i];
            repeat (4) @(posedge core_clk);
            sclk <= 1'b1;
            repeat (4) @(posedge core_clk);
            sclk <= 1'b0;
        end
        // released data line shows the inverse, so a stale bit cannot pass
        sdata <= ~w[0];
        repeat (4) @(posedge core_clk);
        load_strobe <= 1'b1;
        repeat (6) @(posedge core_clk);
        load_strobe <= 1'b0;
        repeat (4) @(posedge core_clk);
    endtask : send_word
endmodule : serial_host
`default_nettype wire

// ===== bench/synth_serial_load_and_power_ctrl_tb.sv
`default_nettype none
module synth_serial_load_and_power_ctrl_tb import synth_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk = 1'b0;
    logic resetn = 1'b0;
    logic sclk, sdata, load_strobe;
    logic chip_enable = 1'b1;
    logic rf_output_power_down_n = 1'b1;
    logic charge_pump_drive = 1'b0;
    logic dig_ld = 1'b0, ana_ld = 1'b0, rf_div = 1'b0, ref_div = 1'b0;
    logic [7:0] bus_addr = 8'h00;
    logic [31:0] bus_wdata = 32'h0000_0000;
    logic bus_wr = 1'b0, bus_rd = 1'b0;
    logic [31:0] bus_rdata, rd;
    logic cp_out, cp_oe, chip_powered, main_rf_output, monitor_mux_output, exp_mux;
    int err_count = 0;
    int comparisons = 0;
    always #20 core_clk = ~core_clk;
    synth_serial_load_and_power_ctrl synth_serial_load_and_power_ctrl_inst (
        .core_clk(core_clk), .resetn(resetn), .sclk(sclk), .sdata(sdata), .load_strobe(load_strobe),
        .chip_enable(chip_enable), .rf_output_power_down_n(rf_output_power_down_n),
        .charge_pump_drive(charge_pump_drive), .digital_lock_detect(dig_ld), .analog_lock_detect(ana_ld),
        .scaled_rf_div(rf_div), .scaled_ref_div(ref_div), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
        .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .charge_pump_output(cp_out),
        .charge_pump_output_oe(cp_oe), .chip_powered(chip_powered), .main_rf_output(main_rf_output),
        .monitor_mux_output(monitor_mux_output)
    );
    serial_host serial_host_inst (.core_clk(core_clk), .sclk(sclk), .sdata(sdata), .load_strobe(load_strobe));
    // ------------------------------------------------------------
    // bus access and comparison
    // ------------------------------------------------------------
    task automatic bus_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        bus_wr <= 1'b1;
        bus_addr <= a;
        bus_wdata <= d;
        @(posedge core_clk);
        bus_wr <= 1'b0;
    endtask : bus_write
    task automatic bus_read(input logic [7:0] a, output logic [31:0] d);
        @(posedge core_clk);
        bus_rd <= 1'b1;
        bus_addr <= a;
        @(posedge core_clk);
        bus_rd <= 1'b0;
        #1 d = bus_rdata;
    endtask : bus_read
    task automatic check32(input string n, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask : check32
    task automatic check1(input string n, input logic e, input logic g);
        comparisons++;
        if (g !== e) begin
            err_count++;
            $display("ERROR %s expected %b seen %b", n, e, g);
        end
    endtask : check1
    task automatic settle();
        repeat (8) @(posedge core_clk);
        #1;
    endtask : settle
    task automatic summarize();
        $display("checks %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : summarize
    initial begin
        repeat (90000) @(posedge core_clk);
        err_count++;
        summarize();
    end
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    initial begin
        repeat (3) @(posedge core_clk);
        resetn <= 1'b1;
        repeat (8) @(posedge core_clk);
        bus_read(OFS_STATUS, rd);
        check32("status idle", 32'h0000_0003, rd);
        bus_read(OFS_CONTROL, rd);
        check32("control reset", CONTROL_RESET, rd);
        serial_host_inst.send_word(32'ha5c3_1e73);
        settle();
        bus_read(8'h0c, rd);
        check32("word 3", 32'ha5c3_1e73, rd);
        bus_read(OFS_STATUS, rd);
        check32("status load", 32'h0001_0033, rd);
        serial_host_inst.send_word(32'h0000_0046);
        charge_pump_drive <= ~charge_pump_drive;
        settle();
        check1("rf on", 1'b1, main_rf_output);
        check1("cp out", 1'b1, cp_out);
        rf_output_power_down_n <= 1'b0;
        settle();
        check1("rf pin off", 1'b0, main_rf_output);
        check1("pin keeps power", 1'b1, chip_powered);
        rf_output_power_down_n <= 1'b1;
        // codes 6 and 7 are unused selects and must read as a low output
        for (int s = 0; s < 8; s++) begin
            serial_host_inst.send_word({2'h0, s[2:0], 23'h0, 4'h4});
            for (int p = 0; p < 2; p++) begin
                charge_pump_drive <= p[0];
                ref_div <= p[0];
                rf_div <= ~p[0];
                ana_ld <= p[0];
                dig_ld <= ~p[0];
                settle();
                exp_mux = (s == 1) ? 1'b1 : (s == 2) ? ref_div : (s == 3) ? rf_div :
                    (s == 4) ? ana_ld : (s == 5) ? dig_ld : 1'b0;
                check1("monitor", exp_mux, monitor_mux_output);
                check1("cp follows", p[0], cp_out);
            end
        end
        serial_host_inst.send_word(32'h0000_0024);
        settle();
        check1("swpd power", 1'b0, chip_powered);
        check1("swpd hiz", 1'b0, cp_oe);
        check1("swpd rf", 1'b0, main_rf_output);
        serial_host_inst.send_word(32'h0000_0004);
        chip_enable <= 1'b0;
        settle();
        check1("ce power", 1'b0, chip_powered);
        check1("ce hiz", 1'b0, cp_oe);
        check1("ce rf", 1'b0, main_rf_output);
        chip_enable <= 1'b1;
        settle();
        check1("ce back rf", 1'b1, main_rf_output);
        bus_read(8'h0c, rd);
        check32("word kept", 32'ha5c3_1e73, rd);
        bus_write(OFS_CONTROL, 32'h0000_0000);
        serial_host_inst.send_word(32'h1234_5673);
        settle();
        bus_read(8'h0c, rd);
        check32("refused load", 32'ha5c3_1e73, rd);
        bus_read(8'h80, rd);
        check32("unmapped", 32'h0000_0000, rd);
        bus_write(OFS_CONTROL, 32'h0000_0001);
        serial_host_inst.send_word(32'h1234_567f);
        settle();
        bus_read(8'h3c, rd);
        check32("word 15", 32'h1234_567f, rd);
        summarize();
    end
endmodule : synth_serial_load_and_power_ctrl_tb
`default_nettype wire
